// ---- rtl/goose_pkg.sv ----
// Constants, register map and types of the event dataset publisher
// Operation
// - Eight transmit and eight receive datasets, each configured on its own.
// - Dataset one sends as soon as any of its items changes.
// - Dataset one sends only when it holds at least one digital item.
// - Datasets two to eight are checked for changes once per 100 ms.
// - A scan that finds a change sends one message, otherwise nothing.
// - Every enabled dataset, dataset one only while it holds a digital item, keeps sending its periodic integrity message while it is not blocked.
// - An oscillating item blocks its dataset for at least one second.
// - While blocked, an alert names the lowest blocked dataset and its oscillating item.
// - Received message matches a sender only on identity and application id.
// - Each remote input follows its selected item of its selected sender.
// - New dataset and selection configuration takes effect only at a restart.
// - An address is multicast when bit 0 of its first byte is one.
// - Every sent frame has a multicast destination.
// - A unicast setting is replaced by the station address with multicast bit.
// - The source address is the fixed station address.
// - Priority resets to 4, VLAN number to 0, both go into the tag.
package goose_pkg;
  localparam int NUM_DS    = 8;
  localparam int NUM_ITEMS = 8;
  localparam int NUM_RI    = 8;
  localparam int CLK_NS    = 10;
  localparam int MS_NS     = 1000000;
  localparam int MS_CYCLES = (MS_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCAN_MS   = 100;
  localparam int HOLD_MS   = 1000;
  localparam int OSC_LIMIT = 20;

  localparam logic [2:0]  PRIO_RST   = 3'h4;
  localparam logic [11:0] VID_RST    = 12'h000;
  localparam logic [15:0] APPID_RST  = 16'h0000;
  localparam logic [15:0] PERIOD_RST = 16'h03E8;
  localparam logic [47:0] MCAST_BIT  = 48'h0100_0000_0000;
  localparam int          MCAST_POS  = 40;
  // Arbitrary neutral station address
  localparam logic [47:0] STATION_ADDR = 48'h0200_0000_0A01;

  localparam int          ADDR_W   = 10;
  localparam logic [9:0]  A_STATUS = 10'h000;
  localparam logic [9:0]  A_MASK   = 10'h004;
  localparam logic [9:0]  A_ALERT  = 10'h008;
  localparam logic [9:0]  A_REMOTE = 10'h00C;
  localparam logic [9:0]  A_SEL_LO = 10'h010;
  localparam logic [9:0]  A_SEL_HI = 10'h014;
  localparam logic [1:0]  PG_TX    = 2'h1;
  localparam logic [1:0]  PG_RX    = 2'h2;
  localparam logic [2:0]  F_CTRL   = 3'h0;
  localparam logic [2:0]  F_DST_LO = 3'h1;
  localparam logic [2:0]  F_DST_HI = 3'h2;
  localparam logic [2:0]  F_APPID  = 3'h3;
  localparam logic [2:0]  F_IDENT  = 3'h4;
  localparam int          CTRL_EN    = 0;
  localparam int          CTRL_DMASK = 8;
  localparam int          CTRL_PRIO  = 16;
  localparam int          CTRL_VID   = 20;
  localparam int          PERIOD_POS = 16;
  localparam int          ST_TX  = 0;
  localparam int          ST_RX  = 1;
  localparam int          ST_OSC = 2;

  typedef struct packed {
    logic        enable;
    logic [7:0]  digital_mask;
    logic [2:0]  tx_tag_priority;
    logic [11:0] tx_tag_vlan_number;
    logic [47:0] tx_destination_address_setting;
    logic [15:0] tx_application_identifier;
    logic [15:0] period_ms;
    logic [31:0] tx_sender_identity_string;
  } tx_cfg_s;

  typedef struct packed {
    logic [31:0] rx_expected_sender_identity;
    logic [15:0] rx_expected_application_identifier;
  } rx_cfg_s;

  localparam tx_cfg_s TX_CFG_RST = '{1'b0, 8'h00, PRIO_RST, VID_RST, 48'h0, APPID_RST,
                                     PERIOD_RST, 32'h0};
  localparam rx_cfg_s RX_CFG_RST = '{32'h0, APPID_RST};

  function automatic logic [2:0] first_set(input logic [7:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) r = 3'(i);
    end
    return r;
  endfunction

  function automatic logic is_multicast(input logic [47:0] mac);
    return mac[MCAST_POS];
  endfunction
endpackage

// ---- rtl/osc_guard.sv ----
// Oscillation guard for one transmit dataset
`timescale 1ns/1ps
`default_nettype none
module osc_guard #(
  parameter int LIMIT = goose_pkg::OSC_LIMIT
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_sec_tick,
  input  wire logic [7:0] i_items,
  output logic            o_suppress,
  output logic            o_onset,
  output logic [2:0]      o_item
);
  import goose_pkg::*;
  if (LIMIT < 1 || LIMIT > 254) begin : g_chk
    $error("osc_guard: LIMIT out of range");
  end

  typedef struct packed {
    logic [7:0] last;
    logic [7:0] cnt;
    logic       susp;
    logic       onset;
    logic [2:0] item;
  } state_s;

  state_s s;
  state_s n;

  always_comb begin
    n = s;
    n.onset = 1'b0;
    n.last = i_items;
    if ((i_items ^ s.last) != 8'h00) begin
      if (s.cnt != 8'hFF) n.cnt = s.cnt + 8'h01;
      if (!s.susp) n.item = first_set(i_items ^ s.last);
    end
    if (i_sec_tick) begin
      n.cnt = 8'h00;
      // Held for a whole second window and again while it keeps toggling
      n.susp = (s.cnt > 8'(LIMIT));
      n.onset = n.susp && !s.susp;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) s <= '0;
    else s <= n;
  end

  assign o_suppress = s.susp;
  assign o_onset    = s.onset;
  assign o_item     = s.item;
endmodule
`default_nettype wire

// ---- rtl/goose_dataset_publisher.sv ----
// Event dataset publisher: transmit scheduling, receive matching, registers
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module goose_dataset_publisher #(
  parameter int          MS_CYCLES_P    = goose_pkg::MS_CYCLES,
  parameter int          OSC_LIMIT_P    = goose_pkg::OSC_LIMIT,
  parameter logic [47:0] STATION_ADDR_P = goose_pkg::STATION_ADDR
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_rst,
  input  wire logic [goose_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [31:0]               i_wdata,
  input  wire logic                      i_wr,
  input  wire logic                      i_rd,
  output logic [31:0]                    o_rdata,
  output logic                           o_irq,
  input  wire logic                      i_restart,
  input  wire logic [goose_pkg::NUM_DS-1:0][7:0] i_items,
  input  wire logic                      i_tx_ready,
  output logic                           o_tx_valid,
  output logic [2:0]                     o_tx_dataset,
  output logic                           o_tx_integrity,
  output logic [47:0]                    o_tx_dst,
  output logic [47:0]                    o_tx_src,
  output logic [2:0]                     o_tx_prio,
  output logic [11:0]                    o_tx_vid,
  output logic [15:0]                    o_tx_appid,
  output logic [31:0]                    o_tx_identity,
  output logic [7:0]                     o_tx_items,
  input  wire logic                      i_rx_valid,
  input  wire logic [31:0]               i_rx_identity,
  input  wire logic [15:0]               i_rx_appid,
  input  wire logic [7:0]                i_rx_items,
  output logic [goose_pkg::NUM_RI-1:0]   o_remote_in,
  output logic                           o_osc_alert,
  output logic [2:0]                     o_osc_dataset,
  output logic [2:0]                     o_oscillation_alert_item
);
  import goose_pkg::*;
  localparam int DIV_W  = $clog2(MS_CYCLES_P + 1);
  localparam int SCAN_W = $clog2(SCAN_MS + 1);
  localparam int SEC_W  = $clog2(HOLD_MS + 1);

  if (MS_CYCLES_P < 2) begin : g_chk_div
    $error("goose_dataset_publisher: MS_CYCLES_P must be at least 2");
  end
  if (NUM_DS != 8 || NUM_ITEMS != 8 || NUM_RI != 8) begin : g_chk_size
    $error("goose_dataset_publisher: layout fixed at eight datasets of eight items");
  end

  typedef struct packed {
    tx_cfg_s [NUM_DS-1:0]        tx_stage;
    tx_cfg_s [NUM_DS-1:0]        tx_act;
    rx_cfg_s [NUM_DS-1:0]        rx_stage;
    rx_cfg_s [NUM_DS-1:0]        rx_act;
    logic [NUM_RI-1:0][5:0]      sel_stage;
    logic [NUM_RI-1:0][5:0]      sel_act;
    logic [NUM_DS-1:0][7:0]      snap;
    logic [NUM_DS-1:0][7:0]      rx_items;
    logic [NUM_DS-1:0][15:0]     integ;
    logic [NUM_DS-1:0]           pend_chg;
    logic [NUM_DS-1:0]           pend_int;
    logic [DIV_W-1:0]            div;
    logic [SCAN_W-1:0]           scan;
    logic [SEC_W-1:0]            sec;
    logic                        ms_tick;
    logic                        scan_tick;
    logic                        sec_tick;
    logic [2:0]                  status;
    logic [2:0]                  mask;
    logic                        irq;
    logic [31:0]                 rdata;
    logic                        tx_valid;
    logic [2:0]                  tx_dataset;
    logic                        tx_integrity;
    logic [47:0]                 tx_dst;
    logic [47:0]                 tx_src;
    logic [2:0]                  tx_prio;
    logic [11:0]                 tx_vid;
    logic [15:0]                 tx_appid;
    logic [31:0]                 tx_identity;
    logic [7:0]                  tx_items;
    logic [NUM_RI-1:0]           remote;
    logic                        alert;
    logic [2:0]                  alert_ds;
    logic [2:0]                  alert_item;
  } state_s;

  state_s s;
  state_s n;

  logic [NUM_DS-1:0]      sup;
  logic [NUM_DS-1:0]      onset;
  logic [NUM_DS-1:0][2:0] osc_item;

  for (genvar g = 0; g < NUM_DS; g++) begin : g_osc
    osc_guard #(
      .LIMIT(OSC_LIMIT_P)
    ) u_osc (
      .i_clk     (i_clk),
      .i_rst     (i_rst),
      .i_sec_tick(s.sec_tick),
      .i_items   (i_items[g]),
      .o_suppress(sup[g]),
      .o_onset   (onset[g]),
      .o_item    (osc_item[g])
    );
  end

  always_comb begin
    logic [2:0]        ds;
    logic [2:0]        pick;
    logic [NUM_DS-1:0] ready_ds;
    logic [NUM_DS-1:0] elig;
    logic              hit;
    tx_cfg_s           c;
    ds = i_addr[7:5];
    pick = 3'h0;
    ready_ds = '0;
    elig = '0;
    hit = 1'b0;
    c = TX_CFG_RST;
    n = s;
    n.ms_tick = 1'b0;
    n.scan_tick = 1'b0;
    n.sec_tick = 1'b0;

    // Millisecond, scan and one-second time base
    if (s.div == DIV_W'(MS_CYCLES_P - 1)) begin
      n.div = '0;
      n.ms_tick = 1'b1;
    end else begin
      n.div = s.div + 1'b1;
    end
    if (s.ms_tick) begin
      if (s.scan == SCAN_W'(SCAN_MS - 1)) begin
        n.scan = '0;
        n.scan_tick = 1'b1;
      end else begin
        n.scan = s.scan + 1'b1;
      end
      if (s.sec == SEC_W'(HOLD_MS - 1)) begin
        n.sec = '0;
        n.sec_tick = 1'b1;
      end else begin
        n.sec = s.sec + 1'b1;
      end
    end

    // Dataset and selection writes land in the staged copy; status and mask writes act at once
    if (i_wr) begin
      if (i_addr == A_STATUS) n.status = s.status & ~i_wdata[2:0];
      if (i_addr == A_MASK) n.mask = i_wdata[2:0];
      if (i_addr == A_SEL_LO) n.sel_stage[3:0] = {i_wdata[29:24], i_wdata[21:16],
                                                   i_wdata[13:8], i_wdata[5:0]};
      if (i_addr == A_SEL_HI) n.sel_stage[7:4] = {i_wdata[29:24], i_wdata[21:16],
                                                   i_wdata[13:8], i_wdata[5:0]};
      if (i_addr[9:8] == PG_TX) begin
        case (i_addr[4:2])
          F_CTRL: begin
            n.tx_stage[ds].enable = i_wdata[CTRL_EN];
            n.tx_stage[ds].digital_mask = i_wdata[CTRL_DMASK +: 8];
            n.tx_stage[ds].tx_tag_priority = i_wdata[CTRL_PRIO +: 3];
            n.tx_stage[ds].tx_tag_vlan_number = i_wdata[CTRL_VID +: 12];
          end
          F_DST_LO: n.tx_stage[ds].tx_destination_address_setting[31:0] = i_wdata;
          F_DST_HI: n.tx_stage[ds].tx_destination_address_setting[47:32] = i_wdata[15:0];
          F_APPID: begin
            n.tx_stage[ds].tx_application_identifier = i_wdata[15:0];
            n.tx_stage[ds].period_ms = i_wdata[PERIOD_POS +: 16];
          end
          F_IDENT: n.tx_stage[ds].tx_sender_identity_string = i_wdata;
          default: ;
        endcase
      end
      if (i_addr[9:8] == PG_RX) begin
        if (i_addr[2]) begin
          n.rx_stage[i_addr[5:3]].rx_expected_application_identifier = i_wdata[15:0];
        end else begin
          n.rx_stage[i_addr[5:3]].rx_expected_sender_identity = i_wdata;
        end
      end
    end

    // Staged configuration becomes active only at a restart
    if (i_restart) begin
      n.tx_act = s.tx_stage;
      n.rx_act = s.rx_stage;
      n.sel_act = s.sel_stage;
    end

    // Change and integrity scheduling per dataset
    for (int d = 0; d < NUM_DS; d++) begin
      ready_ds[d] = s.tx_act[d].enable && (d != 0 || s.tx_act[d].digital_mask != 8'h00);
      if (i_items[d] != s.snap[d]) begin
        if (d == 0) n.pend_chg[d] = 1'b1;
        else if (s.scan_tick) n.pend_chg[d] = 1'b1;
      end
      if (s.ms_tick) begin
        if (s.integ[d] >= s.tx_act[d].period_ms - 16'h0001) begin
          n.integ[d] = 16'h0000;
          n.pend_int[d] = 1'b1;
        end else begin
          n.integ[d] = s.integ[d] + 16'h0001;
        end
      end
      if (!ready_ds[d] || sup[d]) begin
        n.pend_chg[d] = 1'b0;
        n.pend_int[d] = 1'b0;
      end
    end
    elig = (s.pend_chg | s.pend_int) & ready_ds & ~sup;

    // Single frame slot, held until the MAC takes it
    if (s.tx_valid && i_tx_ready) n.tx_valid = 1'b0;
    if ((!s.tx_valid || i_tx_ready) && elig != '0) begin
      pick = first_set(elig);
      c = s.tx_act[pick];
      n.tx_valid = 1'b1;
      n.tx_dataset = pick;
      n.tx_integrity = !s.pend_chg[pick];
      if (is_multicast(c.tx_destination_address_setting)) begin
        n.tx_dst = c.tx_destination_address_setting;
      end else begin
        n.tx_dst = STATION_ADDR_P | MCAST_BIT;
      end
      n.tx_src = STATION_ADDR_P;
      n.tx_prio = c.tx_tag_priority;
      n.tx_vid = c.tx_tag_vlan_number;
      n.tx_appid = c.tx_application_identifier;
      n.tx_identity = c.tx_sender_identity_string;
      n.tx_items = i_items[pick];
      n.snap[pick] = i_items[pick];
      n.pend_chg[pick] = 1'b0;
      n.pend_int[pick] = 1'b0;
      n.status[ST_TX] = 1'b1;
    end

    // Receive matching on identity and application id
    if (i_rx_valid) begin
      for (int r = 0; r < NUM_DS; r++) begin
        if (s.rx_act[r].rx_expected_sender_identity == i_rx_identity &&
            s.rx_act[r].rx_expected_application_identifier == i_rx_appid) begin
          n.rx_items[r] = i_rx_items;
          hit = 1'b1;
        end
      end
    end
    if (hit) n.status[ST_RX] = 1'b1;
    for (int k = 0; k < NUM_RI; k++) begin
      n.remote[k] = s.rx_items[s.sel_act[k][5:3]][s.sel_act[k][2:0]];
    end

    // Oscillation alert names the lowest suppressed dataset and its item
    n.alert = (sup != '0);
    n.alert_ds = first_set(sup);
    n.alert_item = osc_item[first_set(sup)];
    if (onset != '0) n.status[ST_OSC] = 1'b1;
    n.irq = ((n.status & n.mask) != 3'h0);

    // Read data stands in the cycle after the strobe only
    n.rdata = 32'h0;
    if (i_rd) begin
      if (i_addr == A_STATUS) n.rdata = {29'h0, s.status};
      if (i_addr == A_MASK) n.rdata = {29'h0, s.mask};
      if (i_addr == A_ALERT) n.rdata = {s.pend_chg, sup, 8'h0, s.alert_item,
                                        1'b0, s.alert_ds, s.alert};
      if (i_addr == A_REMOTE) n.rdata = {24'h0, s.remote};
      if (i_addr == A_SEL_LO) n.rdata = {2'h0, s.sel_stage[3], 2'h0, s.sel_stage[2],
                                         2'h0, s.sel_stage[1], 2'h0, s.sel_stage[0]};
      if (i_addr == A_SEL_HI) n.rdata = {2'h0, s.sel_stage[7], 2'h0, s.sel_stage[6],
                                         2'h0, s.sel_stage[5], 2'h0, s.sel_stage[4]};
      if (i_addr[9:8] == PG_TX) begin
        c = s.tx_stage[ds];
        case (i_addr[4:2])
          F_CTRL: n.rdata = {c.tx_tag_vlan_number, 1'b0, c.tx_tag_priority,
                             c.digital_mask, 7'h0, c.enable};
          F_DST_LO: n.rdata = c.tx_destination_address_setting[31:0];
          F_DST_HI: n.rdata = {16'h0, c.tx_destination_address_setting[47:32]};
          F_APPID: n.rdata = {c.period_ms, c.tx_application_identifier};
          F_IDENT: n.rdata = c.tx_sender_identity_string;
          default: n.rdata = 32'h0;
        endcase
      end
      if (i_addr[9:8] == PG_RX) begin
        if (i_addr[2]) begin
          n.rdata = {16'h0, s.rx_stage[i_addr[5:3]].rx_expected_application_identifier};
        end else begin
          n.rdata = s.rx_stage[i_addr[5:3]].rx_expected_sender_identity;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s <= '0;
      s.tx_stage <= {NUM_DS{TX_CFG_RST}};
      s.tx_act <= {NUM_DS{TX_CFG_RST}};
      s.rx_stage <= {NUM_DS{RX_CFG_RST}};
      s.rx_act <= {NUM_DS{RX_CFG_RST}};
    end else begin
      s <= n;
    end
  end

  assign o_rdata                  = s.rdata;
  assign o_irq                    = s.irq;
  assign o_tx_valid               = s.tx_valid;
  assign o_tx_dataset             = s.tx_dataset;
  assign o_tx_integrity           = s.tx_integrity;
  assign o_tx_dst                 = s.tx_dst;
  assign o_tx_src                 = s.tx_src;
  assign o_tx_prio                = s.tx_prio;
  assign o_tx_vid                 = s.tx_vid;
  assign o_tx_appid               = s.tx_appid;
  assign o_tx_identity            = s.tx_identity;
  assign o_tx_items               = s.tx_items;
  assign o_remote_in              = s.remote;
  assign o_osc_alert              = s.alert;
  assign o_osc_dataset            = s.alert_ds;
  assign o_oscillation_alert_item = s.alert_item;
endmodule
`default_nettype wire

// ---- testbench/goose_checker_assertions.sv ----
// Port checker of the event dataset publisher
`timescale 1ns/1ps
`default_nettype none
module goose_checker #(
  parameter int          MS_CYCLES_P    = 10,
  parameter logic [47:0] STATION_ADDR_P = 48'h0
) (
  input wire logic                        i_clk,
  input wire logic                        i_rst,
  input wire logic                        i_rd,
  input wire logic                        i_restart,
  input wire logic                        i_rx_valid,
  input wire logic                        i_tx_ready,
  input wire logic [31:0]                 o_rdata,
  input wire logic                        o_irq,
  input wire logic                        o_tx_valid,
  input wire logic [2:0]                  o_tx_dataset,
  input wire logic [47:0]                 o_tx_dst,
  input wire logic [47:0]                 o_tx_src,
  input wire logic [7:0]                  o_tx_items,
  input wire logic [goose_pkg::NUM_RI-1:0] o_remote_in,
  input wire logic                        o_osc_alert,
  input wire logic [2:0]                  o_osc_dataset
);
  import goose_pkg::*;
  int unsigned run;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Cycles the alert has stood so far
  always_ff @(posedge i_clk) begin
    run <= (i_rst || !o_osc_alert) ? 0 : run + 1;
  end
  sequence stall_s;
    o_tx_valid && !i_tx_ready;
  endsequence
  sequence held_s;
    o_tx_valid && $stable(o_tx_dataset) && $stable(o_tx_items);
  endsequence
  frame_hold_a: assert property (stall_s |=> held_s)
    else $error("frame moved while stalled");
  dst_mcast_a: assert property (o_tx_valid |-> o_tx_dst[MCAST_POS])
    else $error("unicast destination sent");
  src_fixed_a: assert property (o_tx_valid |-> o_tx_src == STATION_ADDR_P)
    else $error("source address differs");
  read_idle_a: assert property (!i_rd |=> o_rdata == 32'h0)
    else $error("read data outside read slot");
  alert_min_a: assert property ($fell(o_osc_alert) |-> run >= HOLD_MS * MS_CYCLES_P - 1)
    else $error("suppression shorter than hold");
  alert_block_a: assert property (
    $rose(o_tx_valid) && o_osc_alert && $past(o_osc_alert) |-> o_tx_dataset != o_osc_dataset)
    else $error("suppressed dataset sent");
  remote_cause_a: assert property ($changed(o_remote_in) |->
    $past(i_rx_valid, 2) || $past(i_restart) || $past(i_restart, 2))
    else $error("remote input moved without message");
  reset_quiet_a: assert property ($fell(i_rst) |->
    !o_tx_valid && !o_irq && !o_osc_alert && o_remote_in == '0)
    else $error("outputs not idle after reset");
endmodule
bind goose_dataset_publisher goose_checker #(
  .MS_CYCLES_P(MS_CYCLES_P), .STATION_ADDR_P(STATION_ADDR_P)) u_goose_checker (
  .i_clk(i_clk), .i_rst(i_rst), .i_rd(i_rd), .i_restart(i_restart),
  .i_rx_valid(i_rx_valid), .i_tx_ready(i_tx_ready), .o_rdata(o_rdata), .o_irq(o_irq),
  .o_tx_valid(o_tx_valid), .o_tx_dataset(o_tx_dataset), .o_tx_dst(o_tx_dst),
  .o_tx_src(o_tx_src), .o_tx_items(o_tx_items), .o_remote_in(o_remote_in),
  .o_osc_alert(o_osc_alert), .o_osc_dataset(o_osc_dataset));
`default_nettype wire

// ---- testbench/peer_station.sv ----
// Peer station model: takes frames, prompt or slow, and sends event messages
`timescale 1ns/1ps
`default_nettype none
module peer_station (
  input  wire logic        i_clk,
  input  wire logic        i_tx_valid,
  output logic             o_tx_ready,
  output logic             o_rx_valid,
  output logic [31:0]      o_rx_identity,
  output logic [15:0]      o_rx_appid,
  output logic [7:0]       o_rx_items
);
  logic slow;
  initial begin
    slow          = 1'b0;
    o_tx_ready    = 1'b1;
    o_rx_valid    = 1'b0;
    o_rx_identity = 32'h0;
    o_rx_appid    = 16'h0;
    o_rx_items    = 8'h0;
  end
  // Slow mode takes a frame only every other cycle
  always @(posedge i_clk) begin
    o_tx_ready <= slow ? !o_tx_ready : 1'b1;
  end
  // Identifiers are sent as configured at the receiver
  task automatic send(input logic [31:0] id, input logic [15:0] app, input logic [7:0] it);
    @(posedge i_clk);
    o_rx_valid    <= 1'b1;
    o_rx_identity <= id;
    o_rx_appid    <= app;
    o_rx_items    <= it;
    @(posedge i_clk);
    o_rx_valid    <= 1'b0;
    o_rx_identity <= ~id;
    o_rx_appid    <= ~app;
    o_rx_items    <= ~it;
  endtask
endmodule
`default_nettype wire

// ---- testbench/test_goose_dataset_publisher.sv ----
// Self-checking bench of the event dataset publisher
`timescale 1ns/1ps
`default_nettype none
module test_goose_dataset_publisher;
  import goose_pkg::*;
  localparam int MSC = 10;
  logic              i_clk = 1'b0;
  logic              i_rst = 1'b1;
  logic              i_wr = 1'b0;
  logic              i_rd = 1'b0;
  logic              i_restart = 1'b0;
  logic [9:0]        i_addr = 10'h0;
  logic [31:0]       i_wdata = 32'h0;
  logic [7:0][7:0]   i_items = '0;
  logic              i_tx_ready, i_rx_valid;
  logic [31:0]       i_rx_identity, o_rdata, o_tx_identity, rdata;
  logic [15:0]       i_rx_appid, o_tx_appid;
  logic [7:0]        i_rx_items, o_tx_items, o_remote_in, last_items;
  logic              o_irq, o_tx_valid, o_tx_integrity, o_osc_alert, last_int;
  logic [2:0]        o_tx_dataset, o_tx_prio, o_osc_dataset, o_oscillation_alert_item;
  logic [11:0]       o_tx_vid;
  logic [47:0]       o_tx_dst, o_tx_src, last_dst, last_src, last_id;
  logic [14:0]       last_tag;
  int                errors = 0, comparisons = 0, cycles = 0, c0, hold;
  int                cnt [8] = '{default: 0};
  goose_dataset_publisher #(.MS_CYCLES_P(MSC), .OSC_LIMIT_P(6)) u_goose_dataset_publisher (
    .i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_irq, .i_restart, .i_items,
    .i_tx_ready, .o_tx_valid, .o_tx_dataset, .o_tx_integrity, .o_tx_dst, .o_tx_src,
    .o_tx_prio, .o_tx_vid, .o_tx_appid, .o_tx_identity, .o_tx_items, .i_rx_valid,
    .i_rx_identity, .i_rx_appid, .i_rx_items, .o_remote_in, .o_osc_alert, .o_osc_dataset,
    .o_oscillation_alert_item);
  peer_station u_peer_station (.i_clk, .i_tx_valid(o_tx_valid), .o_tx_ready(i_tx_ready),
    .o_rx_valid(i_rx_valid), .o_rx_identity(i_rx_identity), .o_rx_appid(i_rx_appid),
    .o_rx_items(i_rx_items));
  initial begin
    forever #5 i_clk = ~i_clk;
  end
  // Log of frames taken by the peer
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      conclude();
    end
    if (o_tx_valid && i_tx_ready) begin
      cnt[o_tx_dataset] <= cnt[o_tx_dataset] + 1;
      last_dst   <= o_tx_dst;
      last_src   <= o_tx_src;
      last_tag   <= {o_tx_prio, o_tx_vid};
      last_id    <= {o_tx_appid, o_tx_identity};
      last_items <= o_tx_items;
      last_int   <= o_tx_integrity;
    end
  end
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr    <= w;
    i_rd    <= !w;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    #1 rdata = o_rdata;
  endtask
  task automatic rdc(input logic [9:0] a, input logic [31:0] exp, input logic [31:0] m = '1);
    bus(1'b0, a, 32'h0);
    chk(rdata & m, exp);
  endtask
  task automatic restart();
    @(posedge i_clk);
    i_restart <= 1'b1;
    @(posedge i_clk);
    i_restart <= 1'b0;
  endtask
  // Waits up to max cycles for a frame of dataset ds and checks whether one came
  task automatic frame(input int ds, input int max, input logic exp);
    int n0;
    n0 = cnt[ds];
    for (int k = 0; k < max && cnt[ds] == n0; k++) @(negedge i_clk);
    chk(cnt[ds] != n0, exp);
  endtask
  task automatic conclude();
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    rdc(10'h100, {VID_RST, 1'b0, PRIO_RST, 16'h0});
    rdc(10'h10C, {PERIOD_RST, APPID_RST});
    rdc(10'h204, 32'h0);
    rdc(10'h3FC, 32'h0);
    $display("reset values done");
    bus(1'b1, 10'h100, 32'h1235_0101);
    bus(1'b1, 10'h10C, 32'h0000_0042);
    bus(1'b1, 10'h110, 32'hA5A5_0001);
    @(posedge i_clk) i_items[0] <= 8'h01;
    frame(0, 30, 1'b0);
    @(posedge i_clk) i_items[0] <= 8'h00;
    restart();
    @(posedge i_clk) i_items[0] <= 8'h01;
    frame(0, 6, 1'b1);
    chk(last_dst, STATION_ADDR | MCAST_BIT);
    chk(last_src, STATION_ADDR);
    chk(last_tag, {3'h5, 12'h123});
    chk(last_id, 48'h0042_A5A5_0001);
    chk({last_int, last_items}, 9'h001);
    frame(0, 30, 1'b0);
    u_peer_station.slow = 1'b1;
    @(posedge i_clk) i_items[0] <= 8'h03;
    frame(0, 10, 1'b1);
    chk(last_items, 8'h03);
    u_peer_station.slow = 1'b0;
    rdc(10'h000, 32'h1);
    chk(o_irq, 1'b0);
    bus(1'b1, 10'h004, 32'h1);
    repeat (2) @(negedge i_clk);
    chk(o_irq, 1'b1);
    bus(1'b1, 10'h000, 32'h1);
    repeat (2) @(negedge i_clk);
    chk(o_irq, 1'b0);
    $display("dataset one done");
    bus(1'b1, 10'h100, 32'h0004_0001);
    bus(1'b1, 10'h120, 32'h0004_0001);
    bus(1'b1, 10'h124, 32'h0012_3456);
    bus(1'b1, 10'h128, 32'h0000_0100);
    bus(1'b1, 10'h12C, 32'h0);
    restart();
    c0 = cnt[0];
    @(posedge i_clk) i_items[0] <= 8'h07;
    i_items[1] <= 8'h10;
    frame(1, 1010, 1'b1);
    chk(last_dst, 48'h0100_0012_3456);
    chk(cnt[0], c0);
    @(posedge i_clk) i_items[1] <= 8'h30;
    frame(1, 900, 1'b0);
    frame(1, 200, 1'b1);
    chk(last_items, 8'h30);
    frame(1, 1100, 1'b0);
    bus(1'b1, 10'h12C, 32'h0002_0000);
    restart();
    frame(1, 45, 1'b1);
    chk({last_int, last_items}, 9'h130);
    frame(1, 25, 1'b1);
    $display("scan and integrity done");
    bus(1'b1, 10'h12C, 32'h0);
    bus(1'b1, 10'h200, 32'hC0DE_0001);
    bus(1'b1, 10'h204, 32'h0000_0007);
    bus(1'b1, 10'h010, 32'h0000_0502);
    bus(1'b1, 10'h004, 32'h2);
    restart();
    u_peer_station.send(32'hC0DE_0001, 16'h0007, 8'h24);
    repeat (3) @(negedge i_clk);
    chk(o_remote_in, 8'h03);
    chk(o_irq, 1'b1);
    rdc(10'h00C, 32'h3);
    u_peer_station.send(32'hC0DE_0001, 16'h0008, 8'h00);
    u_peer_station.send(32'hC0DE_0002, 16'h0007, 8'h00);
    repeat (3) @(negedge i_clk);
    chk(o_remote_in, 8'h03);
    u_peer_station.send(32'hC0DE_0001, 16'h0007, 8'h04);
    repeat (3) @(negedge i_clk);
    chk(o_remote_in, 8'h01);
    $display("receive done");
    bus(1'b1, 10'h140, 32'h0004_0001);
    restart();
    for (int k = 0; k < 10; k++) begin
      repeat (5) @(posedge i_clk);
      i_items[2][3] <= ~i_items[2][3];
    end
    for (int k = 0; k < 25000 && !o_osc_alert; k++) @(negedge i_clk);
    chk({o_osc_alert, o_osc_dataset, o_oscillation_alert_item}, 7'h53);
    rdc(10'h008, 32'h0004_0065, 32'h00FF_FFFF);
    rdc(10'h000, 32'h4, 32'h4);
    c0 = cnt[2];
    hold = 0;
    @(posedge i_clk) i_items[2:1] <= {8'h01, 8'h31};
    for (int k = 0; k < 30000 && o_osc_alert; k++) begin
      @(negedge i_clk);
      hold++;
    end
    chk(hold >= HOLD_MS * MSC - 20, 1'b1);
    chk(cnt[2], c0);
    $display("oscillation done");
    conclude();
  end
endmodule
`default_nettype wire
